/* ccr_pkg.sv */
// Package with the register map, field positions and timing constants of the control bank.
package ccr_pkg;

    // Register indices carried in address bits 6:3.
    localparam logic [3:0] IDX_RX_DATA  = 4'h2;
    localparam logic [3:0] IDX_TX_DATA  = 4'h3;
    localparam logic [3:0] IDX_ROUTING  = 4'h4;
    localparam logic [3:0] IDX_GAIN     = 4'h5;
    localparam logic [3:0] IDX_OUT_ATT  = 4'h6;
    localparam logic [3:0] IDX_TONE_CTL = 4'h7;
    localparam logic [3:0] IDX_TONE_A   = 4'h8;
    localparam logic [3:0] IDX_TONE_B   = 4'h9;
    localparam logic [3:0] IDX_RANGE    = 4'ha;
    localparam logic [3:0] IDX_BUZZER   = 4'hb;
    localparam int         IDX_FIRST    = 2;
    localparam int         IDX_LAST     = 11;

    // Address byte fields.
    localparam int ADDR_PD_BIT  = 7;
    localparam int ADDR_IDX_MSB = 6;
    localparam int ADDR_IDX_LSB = 3;
    localparam int ADDR_RD_BIT  = 2;
    localparam int ADDR_DF_BIT  = 1;

    // Buzzer register fields.
    localparam int BUZ_EN_BIT  = 7;
    localparam int BUZ_POL_BIT = 6;

    // Power-on value of every register in the bank.
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] BIT_LAST  = 3'h7;

    // Buzzer duty step time and its cycle count at the 100 MHz clock.
    localparam int CLK_PERIOD_NS = 10;
    localparam int BUZ_STEP_NS   = 1000;
    localparam int BUZ_STEP_CYC  = (BUZ_STEP_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   BUZ_STEP_NS / CLK_PERIOD_NS;

    // Serial port sequencing states.
    typedef enum logic [1:0] {
        ST_ADDR,
        ST_DATA,
        ST_DONE
    } ccr_state_e;

    // Decoded settings handed to the analog and tone logic.
    typedef struct packed {
        logic [1:0] tx_input_sel;
        logic       sidetone_en;
        logic       earpiece_output;
        logic       extra_amp_output;
        logic       ring_route_enable;
        logic       speech_route_enable;
        logic [3:0] tx_gain;
        logic [3:0] sidetone_gain;
        logic [3:0] earpiece_gain_field;
        logic [3:0] extra_amp_gain_field;
        logic [3:0] tone_gain;
        logic       tone_a_select;
        logic       tone_b_select;
        logic       waveform_select;
        logic       tone_to_transmit;
        logic [7:0] tone_a_frequency;
        logic [7:0] tone_b_frequency;
        logic       range_half;
        logic       range_double;
    } ccr_ctrl_s;

endpackage

/* ccr_bank.sv */
// Control register bank, registers two to eleven, behind the serial control port.
`timescale 1ns/1ps

// Notes on behaviour
// - Receive and transmit data registers each hold one byte, bit 7 most significant.
// - Those data bytes drive the voice paths only in companded mode.
// - Routing bits 7:6 pick transmit input: mute, microphone one, two, three.
// - Routing bit 5 enables the sidetone path.
// - Routing bits 4:3 pick mute, earpiece or extra amplifier; 11 never written.
// - Routing bit 2 connects ring/tone to the selected output.
// - Routing bit 0 connects received speech to the selected output.
// - Gain upper nibble sets transmit gain, 0 to 22.5 dB, 1.5 dB steps.
// - Gain lower nibble sets sidetone gain, -12.5 to -27.5 dB, 1 dB steps.
// - Attenuation nibbles set earpiece and extra amplifier gain, 2 dB steps.
// - Tone control bits 7:4 set tone attenuation in 3 dB steps.
// - Tone control bits 3:2 select muted, second, first or both tones.
// - Tone control bit 1 picks square (0) or sine (1) waveform.
// - Tone control bit 0 routes the tone generator into transmit.
// - Two frequency words, unsigned, set first and second tone frequency.
// - Range bits 1:0 pick standard, halved or doubled; fourth code forbidden.
// - Buzzer bit 7 enables the buzzer; disabled output stays low.
// - Buzzer bit 6 makes the duty the high time (0) or low time (1).
// - Buzzer bits 5:0 hold the unsigned duty number.
// - Address byte bit 2 chooses write or read-back.
// - Address bit 1 announces a data byte; else a lone power instruction.
// - Bit 7 of each byte is shifted first.
module ccr_bank (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic             ctl_cs_n,
    input  wire logic             ctl_sclk,
    input  wire logic             ctl_din,
    output logic                  ctl_dout,
    output logic                  ctl_dout_oe_n,
    input  wire logic             companded_mode,
    output logic                  power_down,
    output logic [7:0]            rx_path_byte,
    output logic                  rx_path_use,
    output logic [7:0]            tx_slot_byte,
    output logic                  tx_slot_use,
    output ccr_pkg::ccr_ctrl_s    ctrl,
    output logic                  buzzer_out
);

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    ccr_pkg::ccr_state_e st;
    logic [7:0]          regs [ccr_pkg::IDX_FIRST:ccr_pkg::IDX_LAST];
    logic                sclk_q;
    logic [2:0]          cnt;
    logic [7:0]          shift_in;
    logic [7:0]          next_shift;
    logic [7:0]          out_sh;
    logic [3:0]          idx;
    logic                rd;
    logic                rise;
    logic                fall;
    logic                byte_end;
    logic                idx_ok;
    logic [7:0]          rd_val;
    logic [3:0]          next_idx;
    logic [6:0]          pre_cnt;
    logic [5:0]          phase;
    logic                buz_high;

    // The serial clock is a synchronous input, so one delayed copy gives its edges.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= ctl_sclk;
        end
    end

    assign rise       = ctl_sclk & ~sclk_q & ~ctl_cs_n;
    assign fall       = ~ctl_sclk & sclk_q & ~ctl_cs_n;
    assign next_shift = {shift_in[6:0], ctl_din};
    assign byte_end   = rise && (cnt == ccr_pkg::BIT_LAST);
    assign next_idx   = next_shift[ccr_pkg::ADDR_IDX_MSB:ccr_pkg::ADDR_IDX_LSB];

    // Bits are taken MSB first on rising serial clock edges; deselect restarts a frame.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt      <= 3'h0;
            shift_in <= ccr_pkg::REG_RESET;
        end else if (ctl_cs_n) begin
            cnt <= 3'h0;
        end else if (rise) begin
            cnt      <= cnt + 3'h1;
            shift_in <= next_shift;
        end
    end

    // Frame sequencing: address byte, then an optional data byte.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st         <= ccr_pkg::ST_ADDR;
            idx        <= 4'h0;
            rd         <= 1'b0;
            power_down <= 1'b0;
        end else if (ctl_cs_n) begin
            st <= ccr_pkg::ST_ADDR;
        end else if (byte_end) begin
            unique case (st)
                ccr_pkg::ST_ADDR: begin
                    power_down <= next_shift[ccr_pkg::ADDR_PD_BIT];
                    idx        <= next_idx;
                    rd         <= next_shift[ccr_pkg::ADDR_RD_BIT];
                    // A lone address byte is only a power instruction.
                    st <= next_shift[ccr_pkg::ADDR_DF_BIT] ? ccr_pkg::ST_DATA
                                                           : ccr_pkg::ST_DONE;
                end
                ccr_pkg::ST_DATA: begin
                    st <= ccr_pkg::ST_DONE;
                end
                ccr_pkg::ST_DONE: begin
                    st <= ccr_pkg::ST_DONE;
                end
            endcase
        end
    end

    // Only registers two to eleven live here; the transmit byte has no read-back.
    always_comb begin
        idx_ok = (next_idx >= 4'(ccr_pkg::IDX_FIRST)) && (next_idx <= 4'(ccr_pkg::IDX_LAST));
        rd_val = 8'h00;
        if (idx_ok && next_idx != ccr_pkg::IDX_TX_DATA) begin
            rd_val = regs[next_idx];
        end
    end

    // Read data is loaded as the address completes so bit 7 is ready before the first edge.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_sh <= 8'h00;
        end else if (byte_end && st == ccr_pkg::ST_ADDR) begin
            out_sh <= rd_val;
        end else if (fall && st == ccr_pkg::ST_DATA && cnt != 3'h0) begin
            out_sh <= {out_sh[6:0], 1'b0};
        end
    end

    assign ctl_dout      = out_sh[7];
    assign ctl_dout_oe_n = ~(st == ccr_pkg::ST_DATA && rd && !ctl_cs_n);

    // A write commits only on the eighth data bit, so an aborted frame changes nothing.
    // Reserved bits are stored as written; the controller keeps them zero.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = ccr_pkg::IDX_FIRST; i <= ccr_pkg::IDX_LAST; i++) begin
                regs[i] <= ccr_pkg::REG_RESET;
            end
        end else if (byte_end && st == ccr_pkg::ST_DATA && !rd &&
                     idx >= 4'(ccr_pkg::IDX_FIRST) && idx <= 4'(ccr_pkg::IDX_LAST)) begin
            regs[idx] <= next_shift;
        end
    end

    // Voice data bytes reach the time-slot paths only while companding is selected.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_path_byte <= 8'h00;
            rx_path_use  <= 1'b0;
            tx_slot_byte <= 8'h00;
            tx_slot_use  <= 1'b0;
        end else begin
            rx_path_use  <= companded_mode;
            tx_slot_use  <= companded_mode;
            rx_path_byte <= companded_mode ? regs[ccr_pkg::IDX_RX_DATA] : 8'h00;
            tx_slot_byte <= companded_mode ? regs[ccr_pkg::IDX_TX_DATA] : 8'h00;
        end
    end

    // Decoded settings are registered so downstream analog switching sees clean levels.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= '0;
        end else begin
            ctrl.tx_input_sel         <= regs[ccr_pkg::IDX_ROUTING][7:6];
            ctrl.sidetone_en          <= regs[ccr_pkg::IDX_ROUTING][5];
            // The illegal code 11 is treated as mute so both amplifiers never drive.
            ctrl.earpiece_output      <= regs[ccr_pkg::IDX_ROUTING][4:3] == 2'h1;
            ctrl.extra_amp_output     <= regs[ccr_pkg::IDX_ROUTING][4:3] == 2'h2;
            ctrl.ring_route_enable    <= regs[ccr_pkg::IDX_ROUTING][2];
            ctrl.speech_route_enable  <= regs[ccr_pkg::IDX_ROUTING][0];
            ctrl.tx_gain              <= regs[ccr_pkg::IDX_GAIN][7:4];
            ctrl.sidetone_gain        <= regs[ccr_pkg::IDX_GAIN][3:0];
            ctrl.earpiece_gain_field  <= regs[ccr_pkg::IDX_OUT_ATT][7:4];
            ctrl.extra_amp_gain_field <= regs[ccr_pkg::IDX_OUT_ATT][3:0];
            ctrl.tone_gain            <= regs[ccr_pkg::IDX_TONE_CTL][7:4];
            ctrl.tone_a_select        <= regs[ccr_pkg::IDX_TONE_CTL][3];
            ctrl.tone_b_select        <= regs[ccr_pkg::IDX_TONE_CTL][2];
            ctrl.waveform_select      <= regs[ccr_pkg::IDX_TONE_CTL][1];
            ctrl.tone_to_transmit     <= regs[ccr_pkg::IDX_TONE_CTL][0];
            ctrl.tone_a_frequency     <= regs[ccr_pkg::IDX_TONE_A];
            ctrl.tone_b_frequency     <= regs[ccr_pkg::IDX_TONE_B];
            // The forbidden range code falls back to the standard range.
            ctrl.range_double <= regs[ccr_pkg::IDX_RANGE][1:0] == 2'h2;
            ctrl.range_half   <= regs[ccr_pkg::IDX_RANGE][1:0] == 2'h1;
        end
    end

    // Buzzer step prescaler and 64-step phase counter.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pre_cnt <= 7'h00;
            phase   <= 6'h00;
        end else if (pre_cnt == 7'(ccr_pkg::BUZ_STEP_CYC - 1)) begin
            pre_cnt <= 7'h00;
            phase   <= phase + 6'h1;
        end else begin
            pre_cnt <= pre_cnt + 7'h1;
        end
    end

    assign buz_high = phase < regs[ccr_pkg::IDX_BUZZER][5:0];

    // Disabled buzzer is held low whatever the polarity bit says.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            buzzer_out <= 1'b0;
        end else if (!regs[ccr_pkg::IDX_BUZZER][ccr_pkg::BUZ_EN_BIT]) begin
            buzzer_out <= 1'b0;
        end else begin
            buzzer_out <= buz_high ^ regs[ccr_pkg::IDX_BUZZER][ccr_pkg::BUZ_POL_BIT];
        end
    end

    // Checks on the port sequencing and decoded outputs.
    sequence s_rd_addr;
        byte_end && st == ccr_pkg::ST_ADDR && next_shift[ccr_pkg::ADDR_DF_BIT] &&
        next_shift[ccr_pkg::ADDR_RD_BIT] && !ctl_cs_n;
    endsequence

    sequence s_pd_only;
        byte_end && st == ccr_pkg::ST_ADDR && !next_shift[ccr_pkg::ADDR_DF_BIT];
    endsequence

    sequence s_wr_route;
        byte_end && st == ccr_pkg::ST_DATA && !rd && idx == ccr_pkg::IDX_ROUTING;
    endsequence

    // A completed write and the register that it lands in.
    sequence s_wr_to(logic [3:0] which);
        byte_end && st == ccr_pkg::ST_DATA && !rd && idx == which;
    endsequence

    // Any other edge, the last one of a cut frame included, commits nothing.
    sequence s_no_commit;
        !(byte_end && st == ccr_pkg::ST_DATA && !rd);
    endsequence

    read_drive_a: assert property (s_rd_addr ##1 !ctl_cs_n |-> !ctl_dout_oe_n)
        else $error("read-back does not drive data out");
    lone_addr_a: assert property (s_pd_only |=> st == ccr_pkg::ST_DONE && ctl_dout_oe_n)
        else $error("lone address byte did not end the frame");
    first_bit_a: assert property (s_rd_addr |=> ctl_dout == $past(rd_val[7]))
        else $error("read-back does not start with bit 7");
    write_commit_a: assert property (s_wr_route |=> regs[ccr_pkg::IDX_ROUTING] == $past(next_shift))
        else $error("completed write not stored");
    route_follow_a: assert property (s_wr_route ##2 1'b1 |->
        ctrl.tx_input_sel == $past(next_shift[7:6], 2) &&
        ctrl.sidetone_en == $past(next_shift[5], 2))
        else $error("routing decode does not follow write");
    out_mutex_a: assert property (!(ctrl.earpiece_output && ctrl.extra_amp_output))
        else $error("both output amplifiers selected");
    range_mutex_a: assert property (!(ctrl.range_half && ctrl.range_double))
        else $error("halved and doubled range together");
    rx_gate_a: assert property (!companded_mode |=> !rx_path_use && rx_path_byte == 8'h00)
        else $error("receive byte used in linear mode");
    buzzer_off_a: assert property (!regs[ccr_pkg::IDX_BUZZER][ccr_pkg::BUZ_EN_BIT] |=> !buzzer_out)
        else $error("disabled buzzer not low");
    buzzer_inv_a: assert property (regs[ccr_pkg::IDX_BUZZER] == 8'hc0 |=> buzzer_out)
        else $error("inverted zero duty not held high");

    // Decode checks look two cycles on: one to store the byte, one to register the settings.
    out_sel_a: assert property (s_wr_to(ccr_pkg::IDX_ROUTING) ##2 1'b1 |->
        ctrl.earpiece_output == ($past(next_shift[4:3], 2) == 2'h1) &&
        ctrl.extra_amp_output == ($past(next_shift[4:3], 2) == 2'h2))
        else $error("output select does not follow write");

    ring_route_a: assert property (s_wr_to(ccr_pkg::IDX_ROUTING) ##2 1'b1 |->
        ctrl.ring_route_enable == $past(next_shift[2], 2) &&
        ctrl.speech_route_enable == $past(next_shift[0], 2))
        else $error("ring or speech route does not follow write");

    gain_follow_a: assert property (s_wr_to(ccr_pkg::IDX_GAIN) ##2 1'b1 |->
        ctrl.tx_gain == $past(next_shift[7:4], 2) &&
        ctrl.sidetone_gain == $past(next_shift[3:0], 2))
        else $error("gain does not follow write");

    att_follow_a: assert property (s_wr_to(ccr_pkg::IDX_OUT_ATT) ##2 1'b1 |->
        ctrl.earpiece_gain_field == $past(next_shift[7:4], 2) &&
        ctrl.extra_amp_gain_field == $past(next_shift[3:0], 2))
        else $error("attenuation does not follow write");

    // Tone control fields; the frequency words pass through whole.
    tone_ctl_a: assert property (s_wr_to(ccr_pkg::IDX_TONE_CTL) ##2 1'b1 |->
        ctrl.tone_gain == $past(next_shift[7:4], 2) &&
        ctrl.tone_a_select == $past(next_shift[3], 2) &&
        ctrl.tone_b_select == $past(next_shift[2], 2))
        else $error("tone gain or select does not follow write");

    tone_mode_a: assert property (s_wr_to(ccr_pkg::IDX_TONE_CTL) ##2 1'b1 |->
        ctrl.waveform_select == $past(next_shift[1], 2) &&
        ctrl.tone_to_transmit == $past(next_shift[0], 2))
        else $error("waveform or tone routing does not follow write");

    freq_a_a: assert property (s_wr_to(ccr_pkg::IDX_TONE_A) ##2 1'b1 |->
        ctrl.tone_a_frequency == $past(next_shift, 2))
        else $error("first frequency word does not follow write");

    freq_b_a: assert property (s_wr_to(ccr_pkg::IDX_TONE_B) ##2 1'b1 |->
        ctrl.tone_b_frequency == $past(next_shift, 2))
        else $error("second frequency word does not follow write");

    range_sel_a: assert property (s_wr_to(ccr_pkg::IDX_RANGE) ##2 1'b1 |->
        ctrl.range_half == ($past(next_shift[1:0], 2) == 2'h1) &&
        ctrl.range_double == ($past(next_shift[1:0], 2) == 2'h2))
        else $error("range does not follow write");

    // Voice bytes follow their registers only while companding is selected.
    rx_byte_a: assert property (companded_mode |=>
        rx_path_use && rx_path_byte == $past(regs[ccr_pkg::IDX_RX_DATA]))
        else $error("receive byte not passed in companded mode");

    tx_byte_a: assert property (companded_mode |=>
        tx_slot_use && tx_slot_byte == $past(regs[ccr_pkg::IDX_TX_DATA]))
        else $error("transmit byte not passed in companded mode");

    tx_gate_a: assert property (!companded_mode |=>
        !tx_slot_use && tx_slot_byte == 8'h00)
        else $error("transmit byte used in linear mode");

    // Cut frames leave the bank alone, and read data moves only on its own edges.
    no_commit_a: assert property (s_no_commit |=>
        $stable(regs[ccr_pkg::IDX_ROUTING]) && $stable(regs[ccr_pkg::IDX_BUZZER]))
        else $error("register changed without a completed write");

    readback_a: assert property (byte_end && st == ccr_pkg::ST_ADDR &&
        next_idx == ccr_pkg::IDX_ROUTING |=> out_sh == $past(regs[ccr_pkg::IDX_ROUTING]))
        else $error("read-back does not return the stored value");

    refuse_rd_a: assert property (byte_end && st == ccr_pkg::ST_ADDR &&
        (next_idx == ccr_pkg::IDX_TX_DATA || next_idx < 4'h2 || next_idx > 4'hb)
        |=> out_sh == 8'h00)
        else $error("write-only or unmapped index reads non-zero");

    dout_hold_a: assert property (!fall && !(byte_end && st == ccr_pkg::ST_ADDR) |=>
        $stable(ctl_dout))
        else $error("read data moved off its shift edge");

    power_bit_a: assert property (byte_end && st == ccr_pkg::ST_ADDR |=>
        power_down == $past(next_shift[ccr_pkg::ADDR_PD_BIT]))
        else $error("power bit not taken from the address byte");

    frame_end_a: assert property (byte_end && st == ccr_pkg::ST_DATA |=>
        st == ccr_pkg::ST_DONE)
        else $error("frame did not end after the data byte");

    deselect_a: assert property (ctl_cs_n |=>
        cnt == 3'h0 && st == ccr_pkg::ST_ADDR && ctl_dout_oe_n)
        else $error("deselect did not restart the frame");

    write_quiet_a: assert property (!rd || st != ccr_pkg::ST_DATA |-> ctl_dout_oe_n)
        else $error("read data driven outside a read");

    // A zero duty with plain polarity holds the buzzer low; the phase moves once a step.
    buzzer_zero_a: assert property (regs[ccr_pkg::IDX_BUZZER] == 8'h80 |=> !buzzer_out)
        else $error("zero duty buzzer not low");

    step_len_a: assert property (pre_cnt != 7'(ccr_pkg::BUZ_STEP_CYC - 1) |=>
        $stable(phase))
        else $error("buzzer phase moved mid step");

endmodule

/* ccr_host.sv */
// Microcontroller model that drives the serial control port of the bank.
`timescale 1ns/1ps
module ccr_host (
    input  wire logic ref_clk,
    output logic      cs_n,
    output logic      sclk,
    output logic      din,
    input  wire logic dout,
    input  wire logic dout_oe_n
);
    // Idle port: deselected, serial clock parked low.
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din  = 1'b0;
    end

    // All changes land on falling edges, well away from the sampling edge.
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Each clock phase is held two cycles because the port samples sclk on ref_clk.
    task automatic shift_out(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            din = b[i];
            idle(2);
            sclk = 1'b1;
            idle(2);
            sclk = 1'b0;
        end
    endtask

    // A released data line shows the inverse so a stale bit is never mistaken for data.
    task automatic frame_end();
        din  = ~din;
        cs_n = 1'b1;
        idle(3);
    endtask

    // Address byte: index in 6:3, bit 2 read, bit 1 data follows, reserved bit 0 zero.
    task automatic write_reg(input logic [3:0] idx, input logic [7:0] v);
        cs_n = 1'b0;
        idle(1);
        shift_out({1'b0, idx, 3'b010}, 8);
        shift_out(v, 8);
        frame_end();
    endtask

    // Read-back: sample dout while sclk is low, just before each rise.
    task automatic read_reg(input logic [3:0] idx, output logic [7:0] v, output logic oe_ok);
        cs_n = 1'b0;
        idle(1);
        shift_out({1'b0, idx, 3'b110}, 8);
        oe_ok = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            idle(2);
            v[i] = dout;
            oe_ok = oe_ok & (dout_oe_n === 1'b0);
            sclk = 1'b1;
            idle(2);
            sclk = 1'b0;
        end
        frame_end();
    endtask

    // Lone address byte, or a frame cut short after n data bits.
    task automatic partial(input logic [7:0] a, input logic [7:0] v, input int n);
        cs_n = 1'b0;
        idle(1);
        shift_out(a, 8);
        shift_out(v, n);
        frame_end();
    endtask
endmodule

/* codec_control_register_bank_bench.sv */
// Self-checking bench for the control register bank.
`timescale 1ns/1ps
module codec_control_register_bank_bench;
    logic               ref_clk = 1'b0;
    logic               nrst = 1'b0;
    logic               companded_mode = 1'b0;
    logic               cs_n, sclk, din, dout, dout_oe_n, power_down;
    logic               rx_use, tx_use, buzzer_out, oe_ok;
    logic [7:0]         rx_byte, tx_byte, rd;
    ccr_pkg::ccr_ctrl_s ctrl;
    logic [7:0]         shadow [16];
    int                 n_errors = 0;
    int                 n_checks = 0;
    int                 highs;
    localparam logic [11:0] ROWS [10] = '{12'h2a5, 12'h35a, 12'h4b5, 12'h55c, 12'h6a3,
                                          12'h79e, 12'h881, 12'h93c, 12'ha02, 12'hb20};

    ccr_bank i_dut (.ref_clk(ref_clk), .nrst(nrst), .ctl_cs_n(cs_n), .ctl_sclk(sclk),
        .ctl_din(din), .ctl_dout(dout), .ctl_dout_oe_n(dout_oe_n),
        .companded_mode(companded_mode), .power_down(power_down), .rx_path_byte(rx_byte),
        .rx_path_use(rx_use), .tx_slot_byte(tx_byte), .tx_slot_use(tx_use), .ctrl(ctrl),
        .buzzer_out(buzzer_out));
    ccr_host i_host (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
        .dout_oe_n(dout_oe_n));

    // Free-running 100 MHz clock.
    always #5 ref_clk = ~ref_clk;

    task automatic report_and_stop();
        if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, e, g);
        end
    endtask

    // Shadow copy is kept only for the indices the bank implements.
    task automatic wr(input logic [3:0] idx, input logic [7:0] v);
        i_host.write_reg(idx, v);
        if (idx >= 2 && idx <= 11) shadow[idx] = v;
    endtask

    // The write-only transmit byte and unmapped indices read back as zero.
    task automatic rdchk(input logic [3:0] idx);
        i_host.read_reg(idx, rd, oe_ok);
        chk("read data", (idx >= 2 && idx <= 11 && idx != 3) ? shadow[idx] : 8'h00, rd);
        chk("read enable", 1'b1, oe_ok);
    endtask

    // Decode that the settings outputs should show for the shadow registers.
    function automatic ccr_pkg::ccr_ctrl_s expect_ctrl();
        ccr_pkg::ccr_ctrl_s c;
        {c.tx_input_sel, c.sidetone_en} = shadow[4][7:5];
        c.earpiece_output = (shadow[4][4:3] == 2'b01);
        c.extra_amp_output = (shadow[4][4:3] == 2'b10);
        c.ring_route_enable = shadow[4][2];
        c.speech_route_enable = shadow[4][0];
        {c.tx_gain, c.sidetone_gain} = shadow[5];
        {c.earpiece_gain_field, c.extra_amp_gain_field} = shadow[6];
        {c.tone_gain, c.tone_a_select, c.tone_b_select, c.waveform_select,
            c.tone_to_transmit} = shadow[7];
        c.tone_a_frequency = shadow[8];
        c.tone_b_frequency = shadow[9];
        c.range_half = (shadow[10][1:0] == 2'b01);
        c.range_double = (shadow[10][1:0] == 2'b10);
        return c;
    endfunction

    // One full 64-step buzzer period, counted after the new setting has settled.
    task automatic buzz(input logic [7:0] v, input int exp_high);
        wr(11, v);
        highs = 0;
        repeat (6400) begin
            @(negedge ref_clk);
            if (buzzer_out === 1'b1) highs++;
        end
        chk("buzzer high cycles", exp_high, highs);
    endtask

    // Main sequence.
    initial begin
        for (int i = 0; i < 16; i++) shadow[i] = 8'h00;
        repeat (16) @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
        chk("reset ctrl", 64'h0, ctrl);
        chk("reset oe", 1'b1, dout_oe_n);
        chk("reset buzzer", 1'b0, buzzer_out);
        rdchk(4'h4);
        for (int r = 0; r < 10; r++) wr(ROWS[r][11:8], ROWS[r][7:0]);
        for (int r = 0; r < 10; r++) rdchk(ROWS[r][11:8]);
        chk("ctrl", expect_ctrl(), ctrl);
        chk("rx byte linear", 8'h00, rx_byte);
        companded_mode = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk("rx byte", shadow[2], rx_byte);
        chk("tx byte", shadow[3], tx_byte);
        chk("use flags", 2'b11, {rx_use, tx_use});
        // Every selection code; output and range never get their forbidden code.
        for (int k = 0; k < 4; k++) begin
            wr(4, {k[1:0], 1'b0, (k == 3) ? 2'b00 : k[1:0], 3'b000});
            wr(7, {4'h0, k[1:0], 2'b00});
            wr(10, {6'h00, (k == 3) ? 2'b00 : k[1:0]});
            chk("ctrl codes", expect_ctrl(), ctrl);
        end
        wr(12, 8'h5a);
        rdchk(4'hc);
        i_host.partial(8'h32, 8'hff, 4);
        rdchk(4'h6);
        i_host.partial(8'h80, 8'h00, 0);
        chk("power down", 1'b1, power_down);
        i_host.partial(8'h00, 8'h00, 0);
        chk("power up", 1'b0, power_down);
        rdchk(4'h5);
        buzz(8'h20, 0);
        buzz(8'ha0, 3200);
        buzz(8'hd0, 4800);
        buzz(8'h80, 0);
        buzz(8'hc0, 6400);
        report_and_stop();
    end

    // Guard against a hung run.
    initial begin
        #1000000;
        n_errors++;
        report_and_stop();
    end
endmodule
